// >>> pkg/crc_defs.svh
/*
  Offsets, bit positions, reset values and ladder constants for the
  comparator reference control block.
  Assumes inclusion by bare name; definitions only.
*/
`ifndef CRC_DEFS_SVH
`define CRC_DEFS_SVH

`define CRC_OFS_REFSEL    4'h0
`define CRC_OFS_LADDER    4'h4
`define CRC_OFS_FIXED     4'h8

`define CRC_BIT_MIR1      7
`define CRC_BIT_MIR2      6
`define CRC_BIT_RSEL1     5
`define CRC_BIT_RSEL2     4

`define CRC_BIT_LAD_EN    7
`define CRC_BIT_LAD_PIN   6
`define CRC_BIT_LAD_RANGE 5
`define CRC_BIT_LAD_SRC   4

`define CRC_BIT_FIX_EN    7
`define CRC_BIT_FIX_STAB  6

`define CRC_RST_REFSEL    2'h0
`define CRC_RST_LADDER    8'h00
`define CRC_RST_FIXED     1'h0

`define CRC_LOW_DEN       6'h18
`define CRC_HIGH_DEN      6'h20
`define CRC_HIGH_OFS      5'h08

`endif

// >>> pkg/crc_lad_if.sv
/*
  Carrier between register file and ladder decoder.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface crc_lad_if;
  import crc_pkg::*;
  logic          enable;
  logic          range;
  logic          source;
  crc_level_type level;
  crc_tap_type   tap_num;
  crc_den_type   tap_den;
  logic          add_neg;
  logic          div_on;
  logic          clamp;
  logic          span_ext;
  modport ctrl (output enable, range, source, level,
                input  tap_num, tap_den, add_neg, div_on, clamp, span_ext);
  modport ladder (input  enable, range, source, level,
                  output tap_num, tap_den, add_neg, div_on, clamp, span_ext);
endinterface
`default_nettype wire

// >>> pkg/crc_pkg.sv
/*
  Types shared by the comparator reference control modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package crc_pkg;
  typedef logic [3:0] crc_level_type;
  typedef logic [4:0] crc_tap_type;
  typedef logic [5:0] crc_den_type;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACK  = 2'b10
  } crc_state_type;
endpackage

// >>> rtl/crc_ladder.sv
/*
  Ladder decoder: turns the stored controls into registered tap,
  divisor, rail and power controls for the analog ladder.
  Assumes controls come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "crc_defs.svh"
module crc_ladder (
  input  wire logic clk_i,      // System clock
  input  wire logic rstn_i,     // Async reset, low
  crc_lad_if.ladder lad         // Controls in, decode out
);
  import crc_pkg::*;

  crc_tap_type num_q, num_d;
  crc_den_type den_q, den_d;
  logic        neg_q, neg_d;
  logic        pwr_q, pwr_d;
  logic        clamp_q, clamp_d;
  logic        ext_q, ext_d;

  always_comb begin
    num_d   = lad.range ? {1'b0, lad.level}
                        : `CRC_HIGH_OFS + {1'b0, lad.level};
    den_d   = lad.range ? `CRC_LOW_DEN : `CRC_HIGH_DEN;
    neg_d   = lad.source;
    ext_d   = lad.source;
    pwr_d   = lad.enable;
    clamp_d = !lad.enable && lad.range && (lad.level == 4'h0);
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      num_q   <= 5'h08;
      den_q   <= 6'h20;
      neg_q   <= 1'b0;
      pwr_q   <= 1'b0;
      clamp_q <= 1'b0;
      ext_q   <= 1'b0;
    end else begin
      num_q   <= num_d;
      den_q   <= den_d;
      neg_q   <= neg_d;
      pwr_q   <= pwr_d;
      clamp_q <= clamp_d;
      ext_q   <= ext_d;
    end
  end

  assign lad.tap_num  = num_q;
  assign lad.tap_den  = den_q;
  assign lad.add_neg  = neg_q;
  assign lad.div_on   = pwr_q;
  assign lad.clamp    = clamp_q;
  assign lad.span_ext = ext_q;
endmodule // crc_ladder
`default_nettype wire

// >>> rtl/crc_top.sv
/*
  Comparator reference control: Wishbone classic register slave,
  reference routing, comparator mirrors, ladder and pin controls.
  Assumes analog blocks act on the control outputs; comparator,
  stable flag and pin levels arrive asynchronously.
*/
`timescale 1ns/1ps
`default_nettype none
`include "crc_defs.svh"
module crc_top (
  input  wire logic        clk_i,                 // 50 MHz clock
  input  wire logic        rstn_i,                // Async reset, low
  input  wire logic        wb_cyc_i,              // Bus cycle
  input  wire logic        wb_stb_i,              // Strobe
  input  wire logic        wb_we_i,               // Write
  input  wire logic [3:0]  wb_adr_i,              // Byte address
  input  wire logic [3:0]  wb_sel_i,              // Byte enables
  input  wire logic [31:0] wb_dat_i,              // Write data
  output logic      [31:0] wb_dat_o,              // Read data
  output logic             wb_ack_o,              // Acknowledge
  input  wire logic        cmp1_out_i,            // Comparator 1 output
  input  wire logic        cmp2_out_i,            // Comparator 2 output
  input  wire logic        cmp1_noninv_src_sel_i, // C1 uses internal ref
  input  wire logic        cmp2_noninv_src_sel_i, // C2 uses internal ref
  input  wire logic        fixed_ref_stable_i,    // Fixed ref settled
  input  wire logic        ref_pin_i,             // Ref pin digital level
  output logic             cmp1_ref_sel_o,        // 1 ladder, 0 fixed
  output logic             cmp2_ref_sel_o,        // 1 ladder, 0 fixed
  output logic             cmp1_ref_node_conn_o,  // Node to C1 input
  output logic             cmp2_ref_node_conn_o,  // Node to C2 input
  output logic             ladder_divider_on_o,   // Divider current
  output crc_pkg::crc_tap_type ladder_tap_num_o,  // Tap numerator
  output crc_pkg::crc_den_type ladder_tap_den_o,  // Tap divisor
  output logic             ladder_add_neg_rail_o, // Add lower rail
  output logic             ladder_span_ext_o,     // Span from ref pins
  output logic             ladder_ground_clamp_o, // Clamp to ground
  output logic             ladder_pin_out_en_o,   // Ladder onto pin
  output logic             pin_dig_out_dis_o,     // Kill pin driver
  output logic             pin_dig_in_dis_o,      // Kill pin detector
  output logic             pin_read_o,            // Pin digital read
  output logic             fixed_ref_enable_o     // Fixed ref power
);
  import crc_pkg::*;

  crc_lad_if lad_if ();

  // Async inputs: first stage only feeds second stage
  logic [1:0] cmp_meta_q, cmp_meta_d;
  logic [1:0] cmp_sync_q, cmp_sync_d;
  logic       stab_meta_q, stab_meta_d;
  logic       stab_sync_q, stab_sync_d;
  logic       pin_meta_q, pin_meta_d;
  logic       pin_sync_q, pin_sync_d;

  always_comb begin
    cmp_meta_d  = {cmp1_out_i, cmp2_out_i};
    cmp_sync_d  = cmp_meta_q;
    stab_meta_d = fixed_ref_stable_i;
    stab_sync_d = stab_meta_q;
    pin_meta_d  = ref_pin_i;
    pin_sync_d  = pin_meta_q;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cmp_meta_q  <= 2'h0;
      cmp_sync_q  <= 2'h0;
      stab_meta_q <= 1'b0;
      stab_sync_q <= 1'b0;
      pin_meta_q  <= 1'b0;
      pin_sync_q  <= 1'b0;
    end else begin
      cmp_meta_q  <= cmp_meta_d;
      cmp_sync_q  <= cmp_sync_d;
      stab_meta_q <= stab_meta_d;
      stab_sync_q <= stab_sync_d;
      pin_meta_q  <= pin_meta_d;
      pin_sync_q  <= pin_sync_d;
    end
  end

  function automatic logic hit(input logic [3:0] adr,
                               input logic [3:0] ofs);
    hit = (adr == ofs);
  endfunction

  crc_state_type state_q, state_d;
  logic [7:0]    rdata_q, rdata_d;
  logic [1:0]    ref_sel_q, ref_sel_d;
  logic [7:0]    lad_q, lad_d;
  logic          fix_q, fix_d;
  logic          conn1_q, conn1_d;
  logic          conn2_q, conn2_d;
  logic          pin_rd_q, pin_rd_d;
  logic          req;
  logic          wr;

  assign req = wb_cyc_i && wb_stb_i;
  // Writes land on the acknowledging edge only, lane 0 carries data
  assign wr  = (state_q == ST_ACK) && req && wb_we_i && wb_sel_i[0];

  always_comb begin
    state_d   = state_q;
    rdata_d   = rdata_q;
    ref_sel_d = ref_sel_q;
    lad_d     = lad_q;
    fix_d     = fix_q;
    unique case (state_q)
      ST_IDLE: begin
        if (req) begin
          state_d = ST_ACK;
          rdata_d = 8'h00;
          if (hit(wb_adr_i, `CRC_OFS_REFSEL)) begin
            rdata_d[`CRC_BIT_MIR1]  = cmp_sync_q[1];
            rdata_d[`CRC_BIT_MIR2]  = cmp_sync_q[0];
            rdata_d[`CRC_BIT_RSEL1] = ref_sel_q[1];
            rdata_d[`CRC_BIT_RSEL2] = ref_sel_q[0];
          end else if (hit(wb_adr_i, `CRC_OFS_LADDER)) begin
            rdata_d = lad_q;
          end else if (hit(wb_adr_i, `CRC_OFS_FIXED)) begin
            rdata_d[`CRC_BIT_FIX_EN]   = fix_q;
            rdata_d[`CRC_BIT_FIX_STAB] = stab_sync_q;
          end
        end
      end
      ST_ACK: begin
        state_d = ST_IDLE;
        if (wr) begin
          if (hit(wb_adr_i, `CRC_OFS_REFSEL)) begin
            // Mirror and unused bits are dropped
            ref_sel_d = {wb_dat_i[`CRC_BIT_RSEL1],
                         wb_dat_i[`CRC_BIT_RSEL2]};
          end else if (hit(wb_adr_i, `CRC_OFS_LADDER)) begin
            lad_d = wb_dat_i[7:0];
          end else if (hit(wb_adr_i, `CRC_OFS_FIXED)) begin
            fix_d = wb_dat_i[`CRC_BIT_FIX_EN];
          end
        end
      end
    endcase
  end

  always_comb begin
    // Node connects only when the comparator picks its internal ref
    conn1_d  = cmp1_noninv_src_sel_i;
    conn2_d  = cmp2_noninv_src_sel_i;
    pin_rd_d = lad_q[`CRC_BIT_LAD_PIN] ? 1'b0 : pin_sync_q;
  end

  // No sleep input: Sleep and wake never touch these registers
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q   <= ST_IDLE;
      rdata_q   <= 8'h00;
      ref_sel_q <= `CRC_RST_REFSEL;
      lad_q     <= `CRC_RST_LADDER;
      fix_q     <= `CRC_RST_FIXED;
      conn1_q   <= 1'b0;
      conn2_q   <= 1'b0;
      pin_rd_q  <= 1'b0;
    end else begin
      state_q   <= state_d;
      rdata_q   <= rdata_d;
      ref_sel_q <= ref_sel_d;
      lad_q     <= lad_d;
      fix_q     <= fix_d;
      conn1_q   <= conn1_d;
      conn2_q   <= conn2_d;
      pin_rd_q  <= pin_rd_d;
    end
  end

  assign lad_if.enable = lad_q[`CRC_BIT_LAD_EN];
  assign lad_if.range  = lad_q[`CRC_BIT_LAD_RANGE];
  assign lad_if.source = lad_q[`CRC_BIT_LAD_SRC];
  assign lad_if.level  = lad_q[3:0];

  crc_ladder u_ladder (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .lad    (lad_if.ladder)
  );

  assign wb_ack_o              = (state_q == ST_ACK);
  assign wb_dat_o              = {24'h000000, rdata_q};
  assign cmp1_ref_sel_o        = ref_sel_q[1];
  assign cmp2_ref_sel_o        = ref_sel_q[0];
  assign cmp1_ref_node_conn_o  = conn1_q;
  assign cmp2_ref_node_conn_o  = conn2_q;
  assign ladder_divider_on_o   = lad_if.div_on;
  assign ladder_tap_num_o      = lad_if.tap_num;
  assign ladder_tap_den_o      = lad_if.tap_den;
  assign ladder_add_neg_rail_o = lad_if.add_neg;
  assign ladder_span_ext_o     = lad_if.span_ext;
  assign ladder_ground_clamp_o = lad_if.clamp;
  assign ladder_pin_out_en_o   = lad_q[`CRC_BIT_LAD_PIN];
  assign pin_dig_out_dis_o     = lad_q[`CRC_BIT_LAD_PIN];
  assign pin_dig_in_dis_o      = lad_q[`CRC_BIT_LAD_PIN];
  assign pin_read_o            = pin_rd_q;
  assign fixed_ref_enable_o    = fix_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_rd_start(logic [3:0] ofs);
    state_q == ST_IDLE && req && !wb_we_i && wb_adr_i == ofs;
  endsequence

  sequence s_wr_acked(logic [3:0] ofs);
    wr && wb_adr_i == ofs;
  endsequence

  chk_ref_sel_route: assert property (
    s_wr_acked(`CRC_OFS_REFSEL) |=>
      cmp1_ref_sel_o == $past(wb_dat_i[5]) &&
      cmp2_ref_sel_o == $past(wb_dat_i[4]))
    else $error("Ref select does not follow write");

  chk_mirror_read: assert property (
    s_rd_start(`CRC_OFS_REFSEL) |=>
      wb_ack_o && wb_dat_o[7:6] == $past(cmp_sync_q))
    else $error("Mirror bits wrong");

  chk_node_gate: assert property (
    !cmp1_noninv_src_sel_i |=> !cmp1_ref_node_conn_o)
    else $error("Node connected without internal source");

  chk_low_bits_zero: assert property (
    s_rd_start(`CRC_OFS_REFSEL) |=> wb_dat_o[3:0] == 4'h0)
    else $error("Unused select bits not zero");

  chk_divider_power: assert property (
    s_wr_acked(`CRC_OFS_LADDER) |-> ##2
      ladder_divider_on_o == $past(wb_dat_i[7], 2))
    else $error("Divider power wrong");

  chk_tap_low_range: assert property (
    lad_q[5] |=> ladder_tap_den_o == 6'h18 &&
      ladder_tap_num_o == {1'b0, $past(lad_q[3:0])})
    else $error("Low range tap wrong");

  chk_tap_high_range: assert property (
    !lad_q[5] |=> ladder_tap_den_o == 6'h20 &&
      ladder_tap_num_o == 5'h08 + {1'b0, $past(lad_q[3:0])})
    else $error("High range tap wrong");

  chk_rail_term: assert property (
    !lad_q[4] |=> !ladder_add_neg_rail_o && !ladder_span_ext_o)
    else $error("Lower rail added with supply span");

  chk_ground_clamp: assert property (
    lad_q[7:5] == 3'b001 && lad_q[3:0] == 4'h0 |=>
      ladder_ground_clamp_o && !ladder_divider_on_o)
    else $error("Ground clamp missing");

  chk_pin_override: assert property (
    ladder_pin_out_en_o |-> pin_dig_out_dis_o && pin_dig_in_dis_o)
    else $error("Pin not overridden");

  chk_pin_read_zero: assert property (
    lad_q[6] |=> !pin_read_o)
    else $error("Pin read not zero");

  chk_ladder_hold: assert property (
    !(wr && wb_adr_i == `CRC_OFS_LADDER) |=> $stable(lad_q))
    else $error("Ladder control changed without write");

  chk_reset_state: assert property (
    !$past(rstn_i) |-> lad_q == 8'h00 && !fix_q)
    else $error("Reset values wrong");

  chk_span_select: assert property (
    lad_q[4] |=> ladder_span_ext_o && ladder_add_neg_rail_o)
    else $error("External span not selected");

  chk_fixed_stable: assert property (
    s_rd_start(`CRC_OFS_FIXED) |=>
      wb_dat_o[7:6] == {fix_q, $past(stab_sync_q)})
    else $error("Fixed control readback wrong");

  chk_select_only: assert property (
    s_rd_start(`CRC_OFS_REFSEL) |=>
      wb_dat_o[5:4] == ref_sel_q && wb_dat_o[31:8] == 24'h0)
    else $error("Select readback wrong");

  chk_ack_single: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("Ack held two cycles");

endmodule // crc_top
`default_nettype wire

// >>> verif/tb_top.sv
/*
  Self-checking bench for the comparator reference control block.
  Assumes crc_pkg, crc_lad_if, crc_ladder and crc_top are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "crc_defs.svh"
module tb_top;
  import crc_pkg::*;
  logic        clk_i, rstn_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [3:0]  wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic        cmp1_out_i, cmp2_out_i, fixed_ref_stable_i, ref_pin_i;
  logic        cmp1_noninv_src_sel_i, cmp2_noninv_src_sel_i;
  logic        cmp1_ref_sel_o, cmp2_ref_sel_o, cmp1_ref_node_conn_o, cmp2_ref_node_conn_o;
  logic        ladder_divider_on_o, ladder_add_neg_rail_o, ladder_span_ext_o;
  logic        ladder_ground_clamp_o, ladder_pin_out_en_o, pin_dig_out_dis_o;
  logic        pin_dig_in_dis_o, pin_read_o, fixed_ref_enable_o;
  crc_tap_type ladder_tap_num_o;
  crc_den_type ladder_tap_den_o;
  int          n_fail, n_tests;
  logic [7:0]  v;
  localparam logic [7:0] clamp_val [3] = '{8'h20, 8'h21, 8'hA0};
  localparam logic [1:0] clamp_exp [3] = '{2'b10, 2'b00, 2'b01};

  crc_top dut_u (
    .clk_i, .rstn_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .cmp1_out_i, .cmp2_out_i,
    .cmp1_noninv_src_sel_i, .cmp2_noninv_src_sel_i, .fixed_ref_stable_i,
    .ref_pin_i, .cmp1_ref_sel_o, .cmp2_ref_sel_o, .cmp1_ref_node_conn_o,
    .cmp2_ref_node_conn_o, .ladder_divider_on_o, .ladder_tap_num_o,
    .ladder_tap_den_o, .ladder_add_neg_rail_o, .ladder_span_ext_o,
    .ladder_ground_clamp_o, .ladder_pin_out_en_o, .pin_dig_out_dis_o,
    .pin_dig_in_dis_o, .pin_read_o, .fixed_ref_enable_o
  );

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Ack and read data taken on the rising edge, request released right after
  task automatic bus(input logic [3:0] a, input logic w, input logic [3:0] s,
                     input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, wb_ack_o, 1'b1);
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(a, 1'b1, 4'hF, {24'h0, d});
  endtask

  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    bus(a, 1'b0, 4'hF, 32'h0);
    chk(rd, {24'h0, e});
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic tend(input string s);
    $display("test %s done, mismatches %0d", s, n_fail);
  endtask

  task automatic rst_chk;
    rdc(`CRC_OFS_REFSEL, 8'h00);
    rdc(`CRC_OFS_LADDER, 8'h00);
    rdc(`CRC_OFS_FIXED, 8'h00);
    chk(32'(ladder_tap_num_o), 32'h8);
    chk(32'(ladder_tap_den_o), 32'h20);
    chk(32'({ladder_divider_on_o, ladder_pin_out_en_o, fixed_ref_enable_o}), 32'h0);
    chk(32'({cmp1_ref_sel_o, cmp2_ref_sel_o}), 32'h0);
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    results();
  end

  initial begin
    {rstn_i, wb_cyc_i, wb_stb_i, wb_we_i, cmp1_out_i, cmp2_out_i} = '0;
    {cmp1_noninv_src_sel_i, cmp2_noninv_src_sel_i, fixed_ref_stable_i, ref_pin_i} = '0;
    wb_adr_i = 4'h0;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    n_fail = 0;
    n_tests = 0;
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    rst_chk();
    tend("reset");
    // Select register: only the two select bits stick
    wr(`CRC_OFS_REFSEL, 8'hFF);
    rdc(`CRC_OFS_REFSEL, 8'h30);
    chk(32'({cmp1_ref_sel_o, cmp2_ref_sel_o}), 32'h3);
    wr(`CRC_OFS_REFSEL, 8'h10);
    settle(1);
    chk(32'({cmp1_ref_sel_o, cmp2_ref_sel_o}), 32'h1);
    tend("select");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      cmp1_out_i <= i[1];
      cmp2_out_i <= i[0];
      cmp1_noninv_src_sel_i <= i[0];
      cmp2_noninv_src_sel_i <= i[1];
      settle(4);
      rdc(`CRC_OFS_REFSEL, {i[1], i[0], 6'h10});
      chk(32'({cmp1_ref_node_conn_o, cmp2_ref_node_conn_o}), 32'({i[0], i[1]}));
    end
    tend("mirror");
    for (int r = 0; r < 2; r++) begin
      for (int lv = 0; lv < 16; lv += 5) begin
        v = {1'b1, 1'b0, r[0], lv[0], lv[3:0]};
        wr(`CRC_OFS_LADDER, v);
        settle(2);
        rdc(`CRC_OFS_LADDER, v);
        chk(32'(ladder_tap_num_o), r ? lv : lv + 8);
        chk(32'(ladder_tap_den_o), r ? 24 : 32);
        chk(32'({ladder_divider_on_o, ladder_ground_clamp_o}), 32'h2);
        chk(32'({ladder_add_neg_rail_o, ladder_span_ext_o}), lv[0] ? 3 : 0);
      end
    end
    tend("ladder");
    for (int i = 0; i < 3; i++) begin
      wr(`CRC_OFS_LADDER, clamp_val[i]);
      settle(2);
      chk(32'({ladder_ground_clamp_o, ladder_divider_on_o}), 32'(clamp_exp[i]));
    end
    tend("clamp");
    @(posedge clk_i);
    ref_pin_i <= 1'b1;
    wr(`CRC_OFS_LADDER, 8'h40);
    settle(4);
    chk(32'({ladder_pin_out_en_o, pin_dig_out_dis_o, pin_dig_in_dis_o}), 32'h7);
    chk(32'(pin_read_o), 32'h0);
    wr(`CRC_OFS_LADDER, 8'h00);
    settle(4);
    chk(32'({ladder_pin_out_en_o, pin_dig_out_dis_o, pin_dig_in_dis_o, pin_read_o}), 32'h1);
    tend("pin");
    wr(`CRC_OFS_FIXED, 8'hFF);
    rdc(`CRC_OFS_FIXED, 8'h80);
    chk(32'(fixed_ref_enable_o), 32'h1);
    @(posedge clk_i);
    fixed_ref_stable_i <= 1'b1;
    settle(4);
    rdc(`CRC_OFS_FIXED, 8'hC0);
    tend("fixed");
    // Unmapped and byte-disabled writes change nothing, unmapped and misaligned reads return zero
    bus(4'hC, 1'b1, 4'hF, 32'hFF);
    rdc(4'hC, 8'h00);
    rdc(4'h1, 8'h00);
    rdc(`CRC_OFS_FIXED, 8'hC0);
    bus(`CRC_OFS_LADDER, 1'b1, 4'hE, 32'hFF);
    rdc(`CRC_OFS_LADDER, 8'h00);
    tend("refused");
    wr(`CRC_OFS_LADDER, 8'hB5);
    repeat (50) @(posedge clk_i);
    rdc(`CRC_OFS_LADDER, 8'hB5);
    // Software parks the ladder clamped and unpowered before Sleep
    wr(`CRC_OFS_LADDER, 8'h20);
    settle(2);
    chk(32'({ladder_divider_on_o, ladder_ground_clamp_o}), 32'h1);
    tend("hold");
    @(posedge clk_i);
    {cmp1_out_i, cmp2_out_i, fixed_ref_stable_i} <= 3'b000;
    wr(`CRC_OFS_FIXED, 8'h80);
    wr(`CRC_OFS_REFSEL, 8'h30);
    @(posedge clk_i);
    rstn_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    rst_chk();
    tend("second reset");
    results();
  end
endmodule // tb_top
`default_nettype wire
